// File: common/cpr_register_port_map.svh
/*
 * Constants of the CPU register port: reset values, open-drain enable and level encodings,
 * the interrupt cause address and synchroniser width and reset value.
 * Assumes inclusion by bare name from the package and the design.
 */
`ifndef CPR_REGISTER_PORT_MAP_SVH
`define CPR_REGISTER_PORT_MAP_SVH

// Register address whose read acknowledges a MAC's interrupt events
`define CPR_IRQ_CAUSE_ADDR 10'h000
// Reset value of captured address, port and data
`define CPR_ADDR_RST       10'h000
`define CPR_PORT_RST       3'h0
`define CPR_DATA_RST       8'h00
// Reset value of pending interrupt flags
`define CPR_IRQ_RST        8'h00
// Open-drain enables: high means released
`define CPR_OE_OFF         1'b1
`define CPR_OE_ALL_OFF     8'hff
// Level driven on every open-drain pin while enabled
`define CPR_OD_LOW         8'h00
// Width of the synchronised pin bundle
`define CPR_SYNC_W         32
// Synchroniser reset: idle pin levels, strobes high and interrupt pins pulled up
`define CPR_SYNC_RST       32'he00000ff

`endif

// File: common/cpr_pkg.sv
/*
 * Types of the CPU register port: bus modes and access states.
 * Assumes the map header sits on the include path.
 */
package cpr_pkg;
    `include "cpr_register_port_map.svh"

    // Packet bus modes selected at board level
    typedef enum logic [1:0] {
        CPR_MODE_FULL,
        CPR_MODE_NARROW,
        CPR_MODE_SPLIT
    } cpr_mode_t;

    // Host access sequencer states
    typedef enum logic [2:0] {
        CPR_IDLE,
        CPR_RD_REQ,
        CPR_RD_WAIT,
        CPR_RD_DRV,
        CPR_RD_RDY,
        CPR_WR_CAP,
        CPR_WR_CMT,
        CPR_WR_RDY
    } cpr_state_t;
endpackage

// File: hw/cpr_register_port.sv
/*
 * Strobe-driven 8-bit host register port for eight MAC ports, with the
 * per-MAC open-drain interrupt pins and their split-mode reuse.
 * Assumes the host keeps strobes, address and write data steady as the
 * pins demand, and that MAC register logic answers reg_rd with
 * reg_rvalid one or more cycles later on the same clock.
 */
`timescale 1ns/100ps
`include "cpr_register_port_map.svh"

module cpr_register_port
    import cpr_pkg::*;
#(
    parameter int NUM_MACS = 8,
    parameter int ADDR_W   = 10,
    parameter int DATA_W   = 8
) (
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire cpr_mode_t         bus_mode,
    input  wire logic              cs_n,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic [2:0]        cps,
    input  wire logic [9:0]        cadd,
    input  wire logic [7:0]        cdat_in,
    output logic      [7:0]        cdat_out,
    output logic                   cdat_oe_n,
    output logic                   rdy_n_out,
    output logic                   rdy_n_oe_n,
    input  wire logic [7:0]        irq_pin_in,
    output logic      [7:0]        irq_pin_out,
    output logic      [7:0]        irq_pin_oe_n,
    output logic      [2:0]        reg_port,
    output logic      [9:0]        reg_addr,
    output logic      [7:0]        reg_wdata,
    output logic                   reg_rd,
    output logic                   reg_wr,
    input  wire logic [7:0]        reg_rdata,
    input  wire logic              reg_rvalid,
    input  wire logic [7:0]        mac_event,
    output logic      [2:0]        tx_port_sel,
    output logic                   tx_first,
    output logic                   tx_last
);

    // Widths are fixed by the pin-out
    if (NUM_MACS != 8 || ADDR_W != 10 || DATA_W != 8) begin : g_chk
        $error("cpr_register_port serves 8 MACs, 10-bit address, 8-bit data only");
    end

    logic [`CPR_SYNC_W-1:0] sync1;
    logic [`CPR_SYNC_W-1:0] sync2;
    cpr_state_t             state;
    cpr_state_t             next_state;
    logic [7:0]             pending;
    logic [7:0]             next_pending;
    logic                   cs_act;
    logic                   rd_act;
    logic                   wr_act;
    logic [2:0]             s_cps;
    logic [9:0]             s_cadd;
    logic [7:0]             s_cdat;
    logic [7:0]             s_irq;
    logic                   is_split;
    logic                   cause_read;

    // Two-stage synchroniser for every pin input
    // Reset to idle pin levels, else the strobes look asserted and a false access follows
    always_ff @(posedge mclk) begin
        if (reset) begin
            sync1 <= `CPR_SYNC_RST;
            sync2 <= `CPR_SYNC_RST;
        end else begin
            sync1 <= {cs_n, rd_n, wr_n, cps, cadd, cdat_in, irq_pin_in};
            sync2 <= sync1;
        end
    end

    // Active-low pins decoded to active-high levels
    assign cs_act = ~sync2[31];
    assign rd_act = ~sync2[30];
    assign wr_act = ~sync2[29];
    assign s_cps  = sync2[28:26];
    assign s_cadd = sync2[25:16];
    assign s_cdat = sync2[15:8];
    assign s_irq  = sync2[7:0];
    // Codes outside the enum fall back to full-bus behaviour
    assign is_split = (bus_mode == CPR_MODE_SPLIT);

    // Access sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            CPR_IDLE: begin
                if (cs_act && rd_act) begin
                    next_state = CPR_RD_REQ;
                end else if (cs_act && wr_act) begin
                    next_state = CPR_WR_CAP;
                end
            end
            CPR_RD_REQ: begin
                next_state = CPR_RD_WAIT;
            end
            CPR_RD_WAIT: begin
                if (reg_rvalid) begin
                    next_state = CPR_RD_DRV;
                end
            end
            CPR_RD_DRV: begin
                next_state = rd_act ? CPR_RD_RDY : CPR_IDLE;
            end
            CPR_RD_RDY: begin
                if (!rd_act) begin
                    next_state = CPR_IDLE;
                end
            end
            CPR_WR_CAP: begin
                next_state = CPR_WR_CMT;
            end
            CPR_WR_CMT: begin
                next_state = wr_act ? CPR_WR_RDY : CPR_IDLE;
            end
            CPR_WR_RDY: begin
                if (!wr_act) begin
                    next_state = CPR_IDLE;
                end
            end
        endcase
    end

    // Sequencer state register
    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= CPR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Address and port latched at strobe assertion
    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_addr <= `CPR_ADDR_RST;
            reg_port <= `CPR_PORT_RST;
        end else if (state == CPR_IDLE && cs_act && (rd_act || wr_act)) begin
            reg_addr <= s_cadd;
            reg_port <= s_cps;
        end
    end

    // Write data taken one cycle after the strobe, once settled
    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_wdata <= `CPR_DATA_RST;
        end else if (state == CPR_WR_CAP) begin
            reg_wdata <= s_cdat;
        end
    end

    // Request pulses toward the selected MAC
    assign reg_rd = (state == CPR_RD_REQ);
    assign reg_wr = (state == CPR_WR_CMT);

    // Read data register and bus drive
    always_ff @(posedge mclk) begin
        if (reset) begin
            cdat_out  <= `CPR_DATA_RST;
            cdat_oe_n <= `CPR_OE_OFF;
        end else begin
            if (state == CPR_RD_WAIT && reg_rvalid) begin
                cdat_out <= reg_rdata;
            end
            cdat_oe_n <= !(next_state == CPR_RD_DRV || next_state == CPR_RD_RDY);
        end
    end

    // Ready follows stable read data or captured write data
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdy_n_oe_n <= `CPR_OE_OFF;
        end else begin
            rdy_n_oe_n <= !(next_state == CPR_RD_RDY || next_state == CPR_WR_RDY);
        end
    end
    assign rdy_n_out = 1'b0;

    // Read of the cause register acknowledges that MAC
    assign cause_read = (state == CPR_RD_WAIT) && reg_rvalid && (reg_addr == `CPR_IRQ_CAUSE_ADDR);

    // Pending flags: a new event beats the acknowledge
    always_comb begin
        next_pending = pending;
        if (cause_read) begin
            next_pending[reg_port] = 1'b0;
        end
        next_pending = next_pending | mac_event;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pending <= `CPR_IRQ_RST;
        end else begin
            pending <= next_pending;
        end
    end

    // Interrupt pin enables per bus mode
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_pin_oe_n <= `CPR_OE_ALL_OFF;
        end else if (is_split) begin
            irq_pin_oe_n[7:1] <= 7'h7f;
            irq_pin_oe_n[0]   <= ~(|pending);
        end else begin
            irq_pin_oe_n <= ~pending;
        end
    end
    assign irq_pin_out = `CPR_OD_LOW;

    // Split-mode transmit controls taken from the reused pins
    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_port_sel <= 3'h0;
            tx_first    <= 1'b0;
            tx_last     <= 1'b0;
        end else if (is_split) begin
            tx_port_sel <= s_irq[6:4];
            tx_first    <= s_irq[2];
            tx_last     <= s_irq[1];
        end else begin
            tx_port_sel <= 3'h0;
            tx_first    <= 1'b0;
            tx_last     <= 1'b0;
        end
    end

    // Checks on the sequencer, ready, data drive and interrupt pins
    a_cs_gate: assert property (@(posedge mclk) disable iff (reset)
        state == CPR_IDLE && !cs_act |=> state == CPR_IDLE)
        else $error("access started without chip select");

    a_rd_capture: assert property (@(posedge mclk) disable iff (reset)
        state == CPR_IDLE && cs_act && rd_act |=> reg_rd && reg_addr == $past(s_cadd)
            && reg_port == $past(s_cps))
        else $error("read address not captured");

    a_wr_capture: assert property (@(posedge mclk) disable iff (reset)
        state == CPR_IDLE && cs_act && !rd_act && wr_act |=> ##1 reg_wr
            && reg_addr == $past(s_cadd, 2) && reg_wdata == $past(s_cdat))
        else $error("write capture misordered");

    a_rd_ready: assert property (@(posedge mclk) disable iff (reset)
        $fell(rdy_n_oe_n) && state == CPR_RD_RDY |-> !cdat_oe_n && $past(!cdat_oe_n))
        else $error("ready before read data stable");

    a_wr_ready: assert property (@(posedge mclk) disable iff (reset)
        $fell(rdy_n_oe_n) && state == CPR_WR_RDY |-> $past(reg_wr) && cdat_oe_n)
        else $error("write ready before capture");

    a_data_only_read: assert property (@(posedge mclk) disable iff (reset)
        !cdat_oe_n |-> state == CPR_RD_DRV || state == CPR_RD_RDY)
        else $error("data bus driven outside read");

    a_release: assert property (@(posedge mclk) disable iff (reset)
        (state == CPR_RD_RDY && !rd_act) || (state == CPR_WR_RDY && !wr_act)
            |=> rdy_n_oe_n && cdat_oe_n && state == CPR_IDLE)
        else $error("ready or data not released");

    a_irq_set: assert property (@(posedge mclk) disable iff (reset)
        |mac_event |=> (pending & $past(mac_event)) == $past(mac_event))
        else $error("interrupt event lost");

    a_irq_pins: assert property (@(posedge mclk) disable iff (reset)
        !is_split |=> irq_pin_oe_n == ~$past(pending))
        else $error("interrupt pin does not follow its MAC");

    a_split_any: assert property (@(posedge mclk) disable iff (reset)
        is_split |=> irq_pin_oe_n[0] == !(|$past(pending)) && irq_pin_oe_n[7:1] == 7'h7f)
        else $error("split interrupt pins wrong");

    a_reset_idle: assert property (@(posedge mclk)
        reset |=> state == CPR_IDLE && pending == 8'h00 && rdy_n_oe_n)
        else $error("reset did not clear state");

    c_read: cover property (@(posedge mclk) disable iff (reset)
        state == CPR_RD_RDY ##1 state == CPR_IDLE);
    c_write: cover property (@(posedge mclk) disable iff (reset)
        state == CPR_WR_RDY ##1 state == CPR_IDLE);
    c_ack_race: cover property (@(posedge mclk) disable iff (reset)
        cause_read && mac_event[reg_port]);
    c_split_any: cover property (@(posedge mclk) disable iff (reset)
        is_split && !irq_pin_oe_n[0]);

endmodule

// File: dv/cpr_host_model.sv
/*
 * Host CPU model: strobe-driven byte reads and writes on the pins.
 * Assumes the bench resolves the shared data and ready lines.
 */
`timescale 1ns/100ps
module cpr_host_model (
    input  wire logic       mclk,
    input  wire logic [7:0] cdat_pin,
    input  wire logic       rdy_pin,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic [2:0]      cps,
    output logic [9:0]      cadd,
    output logic [7:0]      hd,
    output logic            hd_en,
    output logic            rd_done,
    output logic [7:0]      rd_data
);
    // Pins idle and released
    initial begin
        {cs_n, rd_n, wr_n, hd_en, rd_done} = 5'h1c;
        {cps, cadd, hd, rd_data} = 29'h0;
    end

    // One access; ok drops if ready never comes or never leaves
    task automatic acc(input logic w, input logic [2:0] p, input logic [9:0] a,
                       input logic [7:0] d, output logic ok);
        int n;
        @(posedge mclk) #1;
        {cps, cadd, hd, hd_en} = {p, a, d, w};
        cs_n = 1'b0;
        {rd_n, wr_n} = {w, !w};
        n = 0;
        while (rdy_pin !== 1'b0 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        ok = n < 40;
        rd_data = cdat_pin;
        #1;
        {cs_n, rd_n, wr_n} = 3'h7;
        rd_done = !w;
        @(posedge mclk) #1;
        rd_done = 1'b0;
        hd_en = 1'b0;
        n = 0;
        while (rdy_pin !== 1'b1 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        ok = ok && n < 40;
        #1;
    endtask

    // Strobes without chip select
    task automatic stray;
        @(posedge mclk) #1;
        {rd_n, wr_n} = 2'h0;
        repeat (6) @(posedge mclk);
        #1;
        {rd_n, wr_n} = 2'h3;
    endtask
endmodule

// File: dv/cpr_register_port_tb.sv
/*
 * Testbench of the CPU register port: host model, MAC register
 * responder, event pulses and a queue scoreboard.
 * Assumes package, design and host model compiled first.
 */
`timescale 1ns/100ps
module cpr_register_port_tb;
    import cpr_pkg::*;
    logic             mclk = 1'b0;
    logic             reset = 1'b1;
    cpr_mode_t        bus_mode = CPR_MODE_FULL;
    logic             cs_n, rd_n, wr_n, cdat_oe_n, rdy_n_out, rdy_n_oe_n, ok;
    logic             reg_rd, reg_wr, tx_first, tx_last, hd_en, rd_done;
    logic             reg_rvalid = 1'b0;
    logic [2:0]       cps, reg_port, tx_port_sel;
    logic [9:0]       cadd, reg_addr;
    logic [7:0]       cdat_out, irq_pin_out, irq_pin_oe_n, reg_wdata, hd, rd_data;
    logic [7:0]       reg_rdata = 8'h00;
    logic [7:0]       mac_event = 8'h00;
    logic [7:0]       drv = 8'h00;
    logic [7:0]       drv_en = 8'h00;
    logic [20:0]      exp_q[$];
    int               num_errors = 0;
    int               check_count = 0;
    int               acts = 0;
    int               lat = 0;
    int               n;
    // Resolved pins: ready and interrupts pulled up, data inverts when floating
    wire logic [7:0]  cdat_pin = !cdat_oe_n ? cdat_out : hd_en ? hd : ~hd;
    wire logic        rdy_pin = rdy_n_oe_n ? 1'b1 : rdy_n_out;
    wire logic [7:0]  irq_pin = (~irq_pin_oe_n & irq_pin_out) | (irq_pin_oe_n & ~(drv_en & ~drv));

    always #4 mclk = ~mclk;

    cpr_register_port dut (.mclk(mclk), .reset(reset), .bus_mode(bus_mode), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .cps(cps), .cadd(cadd), .cdat_in(cdat_pin),
        .cdat_out(cdat_out), .cdat_oe_n(cdat_oe_n), .rdy_n_out(rdy_n_out),
        .rdy_n_oe_n(rdy_n_oe_n), .irq_pin_in(irq_pin), .irq_pin_out(irq_pin_out),
        .irq_pin_oe_n(irq_pin_oe_n), .reg_port(reg_port), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .mac_event(mac_event), .tx_port_sel(tx_port_sel),
        .tx_first(tx_first), .tx_last(tx_last));

    cpr_host_model host (.mclk(mclk), .cdat_pin(cdat_pin), .rdy_pin(rdy_pin), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .cps(cps), .cadd(cadd), .hd(hd), .hd_en(hd_en),
        .rd_done(rd_done), .rd_data(rd_data));

    function automatic logic [7:0] mac_val(input logic [2:0] p, input logic [9:0] a);
        return a[7:0] ^ {p, p, a[9:8]};
    endfunction

    task automatic check(input logic [20:0] seen, input logic [20:0] expv);
        check_count++;
        if (seen !== expv) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    task automatic complete_run;
        $display("errors=%0d checks=%0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Note the expected result, then run the access on the pins
    task automatic go(input logic w, input logic [2:0] p, input logic [9:0] a, input logic [7:0] d);
        exp_q.push_back({p, a, w ? d : mac_val(p, a)});
        host.acc(w, p, a, d, ok);
        check(21'(ok), 21'h1);
        check(21'(cdat_oe_n), 21'h1);
        if (!ok) complete_run();
    endtask

    // MAC register side: answers reads after one or three cycles
    always @(posedge mclk) begin
        #1;
        reg_rvalid = 1'b0;
        reg_rdata = 8'($urandom);
        if (lat > 0) begin
            lat--;
            if (lat == 0) begin
                reg_rvalid = 1'b1;
                reg_rdata = mac_val(reg_port, reg_addr);
            end
        end else if (reg_rd === 1'b1) begin
            lat = reg_addr[0] ? 3 : 1;
        end
    end

    // Scoreboard: each write pulse or host read result takes the oldest note
    always @(posedge mclk) begin
        if (reg_rd === 1'b1 || reg_wr === 1'b1) acts++;
        if (reg_wr === 1'b1 || rd_done === 1'b1)
            check({reg_port, reg_addr, reg_wr ? reg_wdata : rd_data}, exp_q.pop_front());
    end

    initial begin
        void'($urandom(32'h43d9));
        repeat (4) @(posedge mclk);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        check(21'({cdat_oe_n, rdy_n_oe_n, irq_pin_oe_n}), 21'h3ff);
        check({reg_port, reg_addr, reg_wdata}, 21'h0);
        check(21'(acts), 21'h0);
        // Every port read, then every port written, then the top address written and read back to back
        for (int i = 0; i < 16; i++)
            go(i[3], i[2:0], 10'($urandom), 8'($urandom));
        go(1'b1, 3'h7, 10'h3ff, 8'hff);
        go(1'b0, 3'h7, 10'h3ff, 8'h00);
        // Strobes with chip select high go unnoticed
        n = acts;
        host.stray();
        repeat (4) @(posedge mclk);
        #1;
        check(21'({rdy_n_oe_n, 20'(acts - n)}), 21'h100000);
        // One event per MAC: its own line falls, a cause read frees it; full and narrow alternate
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk) #1;
            bus_mode = i[0] ? CPR_MODE_NARROW : CPR_MODE_FULL;
            mac_event = 8'h1 << i;
            @(posedge mclk) #1;
            mac_event = 8'h0;
            repeat (2) @(posedge mclk);
            #1;
            check(21'(irq_pin), {13'h0, ~(8'h1 << i)});
            go(1'b0, i[2:0], 10'h000, 8'h0);
            check(21'(irq_pin), 21'hff);
        end
        // Split mode: pins 7..1 are inputs, pin 0 gathers every MAC
        bus_mode = CPR_MODE_SPLIT;
        drv_en = 8'hfe;
        for (int k = 0; k < 4; k++) begin
            drv = 8'($urandom);
            repeat (5) @(posedge mclk);
            #1;
            check({tx_port_sel, tx_first, tx_last, irq_pin_oe_n}, {drv[6:4], drv[2:1], 8'hff});
        end
        mac_event = 8'h20;
        @(posedge mclk) #1;
        mac_event = 8'h0;
        repeat (2) @(posedge mclk);
        #1;
        check(21'(irq_pin_oe_n), 21'hfe);
        go(1'b0, 3'h5, 10'h000, 8'h0);
        check(21'(irq_pin_oe_n), 21'hff);
        complete_run();
    end
endmodule
